// ---- dv/ssn_scan_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// port checker for the slot scanner
// ----------------------------------------------------------------------------
module ssn_scan_monitor (
	// clock and reset
	input wire logic                clk_sys_i,
	input wire logic                resetn_i,
	// slot bus
	input wire logic [3:0]          slot_sel_o,
	input wire logic                slot_sel_valid_o,
	input wire ssn_pkg::ssn_type_t  slot_type_i,
	// trip supervision
	input wire logic                breaker_closed_i,
	input wire logic                trip_supervision_input_i,
	input wire logic                trip_sup_alarm_o,
	// status
	input wire ssn_pkg::ssn_desig_t desig_o,
	input wire logic [13:0]         slot_alarm_o,
	input wire logic                cfg_error_o,
	input wire logic [13:0]         comm_en_o,
	input wire logic                scan_done_o,
	input wire logic                io_enable_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	// slot A is held for its two cycles before B
	sequence s_hold_a;
		slot_sel_o == ssn_pkg::SLOT_A ##1 slot_sel_o == ssn_pkg::SLOT_A;
	endsequence
	// a slot stands two cycles, then the next letter follows
	sequence s_step;
		##1 $stable(slot_sel_o) ##1 (slot_sel_o == $past(slot_sel_o) + ssn_pkg::SLOT_STEP);
	endsequence

	chk_first_slot: assert property ($rose(slot_sel_valid_o) |-> s_hold_a ##1 slot_sel_o == ssn_pkg::SLOT_B)
		else $error("scan does not start at slot A");
	chk_slot_step: assert property (slot_sel_valid_o && $changed(slot_sel_o) && slot_sel_o != ssn_pkg::SLOT_N |-> s_step)
		else $error("slot order broken");
	chk_done_time: assert property ($rose(resetn_i) |-> ##[28:34] $rose(scan_done_o))
		else $error("scan did not finish in time");
	chk_done_sticky: assert property (scan_done_o |=> scan_done_o)
		else $error("scan done dropped");
	chk_io_gate: assert property (io_enable_o == scan_done_o)
		else $error("io enabled before scan end");
	chk_quiet_before: assert property (!scan_done_o |-> !desig_o.valid && comm_en_o == '0)
		else $error("designation exposed before scan end");
	chk_trip_gate: assert property ($past(resetn_i) |-> trip_sup_alarm_o == ($past(breaker_closed_i) && !$past(trip_supervision_input_i)))
		else $error("trip alarm gate wrong");
	chk_open_block: assert property (!breaker_closed_i |=> !trip_sup_alarm_o)
		else $error("trip alarm with breaker open");
	chk_cfg_or: assert property (cfg_error_o == (|slot_alarm_o))
		else $error("config error not the alarm sum");
	chk_alarm_sticky: assert property (|slot_alarm_o |=> (slot_alarm_o & $past(slot_alarm_o)) == $past(slot_alarm_o))
		else $error("slot alarm cleared");
	chk_slot_a: assert property (slot_sel_valid_o && slot_sel_o == ssn_pkg::SLOT_A && slot_type_i != ssn_pkg::TYPE_VOLT_MEASURE |-> ##[1:2] slot_alarm_o[0])
		else $error("slot A alarm missing");
	chk_slot_b: assert property (slot_sel_valid_o && slot_sel_o == ssn_pkg::SLOT_B && slot_type_i != ssn_pkg::TYPE_EMPTY |-> ##[1:2] slot_alarm_o[1])
		else $error("slot B alarm missing");
	chk_slot_d: assert property (slot_sel_valid_o && slot_sel_o == ssn_pkg::SLOT_D && slot_type_i != ssn_pkg::TYPE_CURR_MEASURE |-> ##[1:2] slot_alarm_o[3])
		else $error("slot D alarm missing");
endmodule : ssn_scan_monitor

bind ssn_scan ssn_scan_monitor i_ssn_scan_monitor (.clk_sys_i, .resetn_i, .slot_sel_o, .slot_sel_valid_o, .slot_type_i,
	.breaker_closed_i, .trip_supervision_input_i, .trip_sup_alarm_o, .desig_o, .slot_alarm_o, .cfg_error_o,
	.comm_en_o, .scan_done_o, .io_enable_o);

// ---- dv/ssn_slot_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// plug-in slot modules: each slot answers its type code while selected
// ----------------------------------------------------------------------------
module ssn_slot_model (
	// slot select from the scanner
	input  wire logic               [3:0]                slot_sel_i,
	input  wire logic                                    sel_valid_i,
	// fitted module per slot
	input  wire ssn_pkg::ssn_type_t [ssn_pkg::NSLOT-1:0] fit_i,
	// answer
	output ssn_pkg::ssn_type_t                           slot_type_o
);
	ssn_pkg::ssn_type_t last_q;

	// remember the last code so an idle bus can show its inverse
	always @(posedge sel_valid_i or slot_sel_i or fit_i) begin
		if (sel_valid_i) begin
			last_q = fit_i[slot_sel_i];
		end
	end

	// unselected bus floats: never let the old code linger as a free answer
	assign slot_type_o = sel_valid_i ? fit_i[slot_sel_i] : ~last_q;
endmodule : ssn_slot_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	// ------------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------------
	logic                                    clk_sys_i = 1'b0;
	logic                                    resetn_i = 1'b0;
	logic                                    breaker_closed_i = 1'b0;
	logic                                    trip_supervision_input_i = 1'b1;
	logic                [3:0]               desig_sel_i = 4'h0;
	logic                [3:0]               slot_sel_o;
	logic                                    slot_sel_valid_o, trip_sup_alarm_o, cfg_error_o, scan_done_o, io_enable_o;
	ssn_pkg::ssn_type_t                      slot_type_i;
	ssn_pkg::ssn_type_t [ssn_pkg::NSLOT-1:0] exp_type_i = '0;
	ssn_pkg::ssn_type_t [ssn_pkg::NSLOT-1:0] fit = '0;
	ssn_pkg::ssn_desig_t                     desig_o;
	ssn_pkg::ssn_totals_t                    totals_o;
	logic                [13:0]              slot_alarm_o, comm_en_o;
	int                                      n_errors = 0;
	int                                      check_count = 0;

	// design and the fitted slot modules
	ssn_scan i_ssn_scan (.clk_sys_i, .resetn_i, .slot_sel_o, .slot_sel_valid_o, .slot_type_i, .exp_type_i,
		.breaker_closed_i, .trip_supervision_input_i, .trip_sup_alarm_o, .desig_sel_i, .desig_o, .totals_o,
		.slot_alarm_o, .cfg_error_o, .comm_en_o, .scan_done_o, .io_enable_o);
	ssn_slot_model i_ssn_slot_model (.slot_sel_i(slot_sel_o), .sel_valid_i(slot_sel_valid_o), .fit_i(fit),
		.slot_type_o(slot_type_i));

	// clock at 100 MHz
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// ------------------------------------------------------------------------
	// helpers: inputs move 1 ns after the edge so no race with sampling
	// ------------------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick

	task chk_val(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	// reset, look once mid-scan, then wait for the end under a bound
	task run_scan;
		resetn_i = 1'b0;
		tick(4);
		resetn_i = 1'b1;
		tick(8);
		chk_bit(io_enable_o, 1'b0);
		chk_bit(desig_o.valid, 1'b0);
		for (int i = 0; i < 40 && scan_done_o !== 1'b1; i++) tick(1);
		chk_bit(scan_done_o, 1'b1);
	endtask : run_scan

	// readback has one cycle latency; two ticks leave margin
	task rd(input logic [3:0] s, input logic v, input logic [7:0] a);
		desig_sel_i = s;
		tick(2);
		chk_bit(desig_o.valid, v);
		chk_val(desig_o.base_a, a);
	endtask : rd

	// ------------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------------
	task test_trip;
		for (int i = 0; i < 4; i++) begin
			{breaker_closed_i, trip_supervision_input_i} = i[1:0];
			tick(2);
			chk_bit(trip_sup_alarm_o, i == 2);
		end
		trip_supervision_input_i = 1'b1;
	endtask : test_trip

	// fully optioned: C,E eight-in, F,G five-out, H arc, M,N comm
	task test_full;
		fit = 56'h66_0000_5443_2301;
		exp_type_i = fit;
		run_scan();
		chk_val(slot_alarm_o, 16'h0000);
		rd(ssn_pkg::SLOT_C, 1'b1, 8'h04);
		rd(4'h4, 1'b1, 8'h0C);
		rd(4'h5, 1'b1, 8'h06);
		rd(4'h6, 1'b1, 8'h0B);
		rd(4'h7, 1'b1, 8'h01);
		chk_val(desig_o.base_b, 16'h0001);
		chk_val(desig_o.base_c, 16'h0001);
		rd(ssn_pkg::SLOT_M, 1'b1, 8'h03);
		rd(ssn_pkg::SLOT_N, 1'b1, 8'h04);
		chk_val(totals_o.di_last, 16'h0013);
		chk_val(totals_o.do_last, 16'h000F);
		chk_val({totals_o.sensor_last, totals_o.fast_last}, 16'h0402);
		chk_val(totals_o.arc_bi_last, 16'h0001);
		chk_val(totals_o.comm_last, 16'h0004);
		chk_val(comm_en_o, 16'h3000);
	endtask : test_full

	// wrong A, filled B, empty D and E, comm in F, wrong card in G
	task test_faults;
		fit = 56'h00_0000_0360_0432;
		exp_type_i = 56'h00_0000_0463_0400;
		run_scan();
		chk_val(slot_alarm_o, 16'h007B);
		chk_bit(cfg_error_o, 1'b1);
		rd(ssn_pkg::SLOT_C, 1'b1, 8'h06);
		rd(4'h4, 1'b0, 8'h00);
		rd(4'h5, 1'b0, 8'h00);
		rd(4'h6, 1'b0, 8'h00);
		chk_val({totals_o.di_last, totals_o.do_last}, 16'h030A);
		chk_val(totals_o.comm_last, 16'h0002);
		chk_val(comm_en_o, 16'h0000);
	endtask : test_faults

	// ------------------------------------------------------------------------
	// verdict, main sequence and watchdog
	// ------------------------------------------------------------------------
	task conclude;
		$display("errors=%0d checks=%0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude

	initial begin
		// hold reset for four cycles; the trip gate flop is cleared while reset is low
		tick(4);
		resetn_i = 1'b1;
		tick(2);
		test_trip();
		test_full();
		test_faults();
		conclude();
	end

	// two full scans of some thirty cycles each; this bound leaves wide margin
	initial begin
		#20000;
		n_errors++;
		conclude();
	end
endmodule : tb_top

// ---- hdl/ssn_scan.sv ----
`timescale 1ns/1ps
module ssn_scan (
	// clock and reset
	input  wire logic                                   clk_sys_i,
	input  wire logic                                   resetn_i,
	// slot modules: select a slot, its type code answers in the same cycle
	output logic                 [3:0]                  slot_sel_o,
	output logic                                        slot_sel_valid_o,
	input  wire ssn_pkg::ssn_type_t                     slot_type_i,
	// expected configuration from the order code, one type per slot
	input  wire ssn_pkg::ssn_type_t [ssn_pkg::NSLOT-1:0] exp_type_i,
	// trip circuit supervision
	input  wire logic                                   breaker_closed_i,
	input  wire logic                                   trip_supervision_input_i,
	output logic                                        trip_sup_alarm_o,
	// designation readback
	input  wire logic                [3:0]              desig_sel_i,
	output ssn_pkg::ssn_desig_t                         desig_o,
	output ssn_pkg::ssn_totals_t                        totals_o,
	// status
	output logic                 [ssn_pkg::NSLOT-1:0]   slot_alarm_o,
	output logic                                        cfg_error_o,
	output logic                 [ssn_pkg::NSLOT-1:0]   comm_en_o,
	output logic                                        scan_done_o,
	output logic                                        io_enable_o
);

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	typedef struct packed {
		ssn_pkg::ssn_state_t                       st;
		logic [3:0]                                slot;
		ssn_pkg::ssn_totals_t                      tot;
		ssn_pkg::ssn_desig_t [ssn_pkg::NSLOT-1:0]  table_;
		logic [ssn_pkg::NSLOT-1:0]                 alarm;
		logic [ssn_pkg::NSLOT-1:0]                 comm_en;
		logic                                      done;
		ssn_pkg::ssn_desig_t                       desig;
	} ssn_scan_state_t;

	ssn_scan_state_t s_q;
	ssn_scan_state_t s_d;

	logic chk_alarm;
	logic chk_accept;

	// ------------------------------------------------------------------------
	// acceptance check of the slot currently selected
	// ------------------------------------------------------------------------
	ssn_slot_check u_check (
		.slot_i     (s_q.slot),
		.found_i    (slot_type_i),
		.expected_i (exp_type_i[s_q.slot]),
		.alarm_o    (chk_alarm),
		.accept_o   (chk_accept)
	);

	// ------------------------------------------------------------------------
	// trip supervision gate, independent of the scan
	// ------------------------------------------------------------------------
	ssn_trip_sup u_trip_sup (
		.clk_sys_i                (clk_sys_i),
		.resetn_i                 (resetn_i),
		.breaker_closed_i         (breaker_closed_i),
		.trip_supervision_input_i (trip_supervision_input_i),
		.trip_sup_alarm_o         (trip_sup_alarm_o)
	);

	// ------------------------------------------------------------------------
	// first free number after a running last-used number
	// ------------------------------------------------------------------------
	function automatic logic [7:0] next_free(input logic [7:0] last);
		return 8'(last + ssn_pkg::FIRST_NUMBER);
	endfunction : next_free

	// last-used number after reserving a group of a given size
	function automatic logic [7:0] reserve(input logic [7:0] last, input logic [7:0] count);
		return 8'(last + count);
	endfunction : reserve

	// ------------------------------------------------------------------------
	// scan sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		ssn_pkg::ssn_desig_t ent;
		ent = ssn_pkg::DESIG_NONE;
		s_d = s_q;
		case (s_q.st)
			ssn_pkg::ST_RESET: begin
				s_d.st = ssn_pkg::ST_CPU;
			end
			ssn_pkg::ST_CPU: begin
				// processor card owns the lowest numbers, before any slot is looked at
				s_d.tot.di_last     = ssn_pkg::CPU_DI_COUNT;
				s_d.tot.do_last     = ssn_pkg::CPU_DO_COUNT;
				s_d.tot.comm_last   = ssn_pkg::CPU_COMM_COUNT;
				s_d.tot.sensor_last = ssn_pkg::ZERO8;
				s_d.tot.fast_last   = ssn_pkg::ZERO8;
				s_d.tot.arc_bi_last = ssn_pkg::ZERO8;
				s_d.slot            = ssn_pkg::SLOT_A;
				s_d.st              = ssn_pkg::ST_SEL;
			end
			ssn_pkg::ST_SEL: begin
				// one cycle of select before sampling lets the type code settle
				s_d.st = ssn_pkg::ST_CHK;
			end
			ssn_pkg::ST_CHK: begin
				s_d.alarm[s_q.slot] = chk_alarm;
				ent.kind = slot_type_i;
				if (chk_accept) begin
					ent.valid = 1'b1;
					case (slot_type_i)
						ssn_pkg::TYPE_VOLT_MEASURE,
						ssn_pkg::TYPE_CURR_MEASURE: begin
							ent.count_a = ssn_pkg::ZERO8;
						end
						ssn_pkg::TYPE_EIGHT_INPUT: begin
							// numbering continues after whatever earlier slots took
							ent.base_a      = next_free(s_q.tot.di_last);
							ent.count_a     = ssn_pkg::CARD_DI_COUNT;
							s_d.tot.di_last = reserve(s_q.tot.di_last, ssn_pkg::CARD_DI_COUNT);
						end
						ssn_pkg::TYPE_FIVE_OUTPUT: begin
							ent.base_a      = next_free(s_q.tot.do_last);
							ent.count_a     = ssn_pkg::CARD_DO_COUNT;
							s_d.tot.do_last = reserve(s_q.tot.do_last, ssn_pkg::CARD_DO_COUNT);
						end
						ssn_pkg::TYPE_ARC: begin
							ent.base_a          = next_free(s_q.tot.sensor_last);
							ent.count_a         = ssn_pkg::ARC_SENSOR_COUNT;
							ent.base_b          = next_free(s_q.tot.fast_last);
							ent.base_c          = next_free(s_q.tot.arc_bi_last);
							s_d.tot.sensor_last = reserve(s_q.tot.sensor_last, ssn_pkg::ARC_SENSOR_COUNT);
							s_d.tot.fast_last   = reserve(s_q.tot.fast_last, ssn_pkg::ARC_FAST_COUNT);
							s_d.tot.arc_bi_last = reserve(s_q.tot.arc_bi_last, ssn_pkg::ARC_BI_COUNT);
						end
						ssn_pkg::TYPE_COMM: begin
							ent.base_a            = next_free(s_q.tot.comm_last);
							ent.count_a           = ssn_pkg::COMM_CARD_COUNT;
							s_d.tot.comm_last     = reserve(s_q.tot.comm_last, ssn_pkg::COMM_CARD_COUNT);
							s_d.comm_en[s_q.slot] = 1'b1;
						end
						default: begin
							ent.valid = 1'b0;
						end
					endcase
				end
				s_d.table_[s_q.slot] = ent;
				// empty or rejected slots simply move on to the next letter
				if (s_q.slot == ssn_pkg::SLOT_LAST) begin
					s_d.st = ssn_pkg::ST_DONE;
				end else begin
					s_d.slot = 4'(s_q.slot + ssn_pkg::SLOT_STEP);
					s_d.st   = ssn_pkg::ST_SEL;
				end
			end
			ssn_pkg::ST_DONE: begin
				s_d.done = 1'b1;
			end
			default: begin
				s_d.st = ssn_pkg::ST_RESET;
			end
		endcase
		// readback is blank until the whole scan has finished
		if (s_q.done && (desig_sel_i < 4'(ssn_pkg::NSLOT))) begin
			s_d.desig = s_q.table_[desig_sel_i];
		end else begin
			s_d.desig = ssn_pkg::DESIG_NONE;
		end
	end

	// ------------------------------------------------------------------------
	// state register; the scan runs exactly once per reset
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign slot_sel_o       = s_q.slot;
	assign slot_sel_valid_o = (s_q.st == ssn_pkg::ST_SEL) || (s_q.st == ssn_pkg::ST_CHK);
	assign desig_o          = s_q.desig;
	assign totals_o         = s_q.done ? s_q.tot : '0;
	assign slot_alarm_o     = s_q.alarm;
	assign cfg_error_o      = |s_q.alarm;
	assign comm_en_o        = s_q.done ? s_q.comm_en : '0;
	assign scan_done_o      = s_q.done;
	// i/o stays disabled until enumeration is complete, even with alarms
	assign io_enable_o      = s_q.done;

endmodule : ssn_scan

// ---- hdl/ssn_slot_check.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// per-slot acceptance check, purely combinational
// ----------------------------------------------------------------------------
module ssn_slot_check (
	// slot under test
	input  wire logic             [3:0] slot_i,
	input  wire ssn_pkg::ssn_type_t     found_i,
	input  wire ssn_pkg::ssn_type_t     expected_i,
	// verdict
	output logic                        alarm_o,
	output logic                        accept_o
);

	// ------------------------------------------------------------------------
	// which module types a slot may hold at all
	// ------------------------------------------------------------------------
	function automatic logic slot_allows(input logic [3:0] slot, input ssn_pkg::ssn_type_t kind);
		logic ok;
		ok = 1'b0;
		case (kind)
			ssn_pkg::TYPE_EMPTY:        ok = 1'b1;
			ssn_pkg::TYPE_EIGHT_INPUT,
			ssn_pkg::TYPE_FIVE_OUTPUT,
			ssn_pkg::TYPE_ARC:          ok = (slot >= ssn_pkg::SLOT_C) && (slot != ssn_pkg::SLOT_D);
			ssn_pkg::TYPE_COMM:         ok = (slot == ssn_pkg::SLOT_M) || (slot == ssn_pkg::SLOT_N);
			default:                    ok = 1'b0;
		endcase
		return ok;
	endfunction : slot_allows

	// fixed slots ignore the expected table; option slots compare to it
	always_comb begin
		alarm_o = 1'b0;
		case (slot_i)
			ssn_pkg::SLOT_A: alarm_o = (found_i != ssn_pkg::TYPE_VOLT_MEASURE);
			ssn_pkg::SLOT_B: alarm_o = (found_i != ssn_pkg::TYPE_EMPTY);
			ssn_pkg::SLOT_D: alarm_o = (found_i != ssn_pkg::TYPE_CURR_MEASURE);
			default: begin
				// empty where a card is expected, or any other content mismatch
				alarm_o = (found_i != expected_i) || !slot_allows(slot_i, found_i);
			end
		endcase
		accept_o = !alarm_o && (found_i != ssn_pkg::TYPE_EMPTY);
	end

endmodule : ssn_slot_check

// ---- hdl/ssn_trip_sup.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// trip circuit supervision alarm gate
// ----------------------------------------------------------------------------
module ssn_trip_sup (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	// breaker and supervision inputs
	input  wire logic breaker_closed_i,
	input  wire logic trip_supervision_input_i,
	// alarm
	output logic      trip_sup_alarm_o
);

	logic alarm_d;
	logic alarm_q;

	// the input is normally closed, so a healthy circuit reads high; an open
	// breaker blocks the alarm because a latched trip shorts the input then
	always_comb begin
		alarm_d = breaker_closed_i && !trip_supervision_input_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			alarm_q <= 1'b0;
		end else begin
			alarm_q <= alarm_d;
		end
	end

	assign trip_sup_alarm_o = alarm_q;

endmodule : ssn_trip_sup

// ---- inc/ssn_pkg.sv ----
// ----------------------------------------------------------------------------
// start-up slot scan and i/o naming: shared constants and types
// ----------------------------------------------------------------------------
package ssn_pkg;

	// ------------------------------------------------------------------------
	// slot map: index 0 is slot A, index 13 is slot N
	// ------------------------------------------------------------------------
	localparam int          NSLOT     = 14;
	localparam logic [3:0]  SLOT_A    = 4'h0;
	localparam logic [3:0]  SLOT_B    = 4'h1;
	localparam logic [3:0]  SLOT_C    = 4'h2;
	localparam logic [3:0]  SLOT_D    = 4'h3;
	localparam logic [3:0]  SLOT_M    = 4'hC;
	localparam logic [3:0]  SLOT_N    = 4'hD;
	localparam logic [3:0]  SLOT_LAST = SLOT_N;
	localparam logic [3:0]  SLOT_STEP = 4'h1;

	// ------------------------------------------------------------------------
	// module type designation codes (arbitrary values, not a maker's codes)
	// ------------------------------------------------------------------------
	typedef logic [3:0] ssn_type_t;
	localparam ssn_type_t TYPE_EMPTY            = 4'h0;
	localparam ssn_type_t TYPE_VOLT_MEASURE     = 4'h1;  // voltage_measure_card
	localparam ssn_type_t TYPE_CURR_MEASURE     = 4'h2;  // current_measure_card
	localparam ssn_type_t TYPE_EIGHT_INPUT      = 4'h3;  // eight_input_card
	localparam ssn_type_t TYPE_FIVE_OUTPUT      = 4'h4;  // five_output_card / five_output_card_alt
	localparam ssn_type_t TYPE_ARC              = 4'h5;
	localparam ssn_type_t TYPE_COMM             = 4'h6;

	// ------------------------------------------------------------------------
	// designation counts and first numbers
	// ------------------------------------------------------------------------
	localparam logic [7:0] CPU_DI_COUNT     = 8'h03;
	localparam logic [7:0] CPU_DO_COUNT     = 8'h05;
	localparam logic [7:0] CPU_COMM_COUNT   = 8'h02;
	localparam logic [7:0] FIRST_NUMBER     = 8'h01;
	localparam logic [7:0] CARD_DI_COUNT    = 8'h08;
	localparam logic [7:0] CARD_DO_COUNT    = 8'h05;
	localparam logic [7:0] ARC_SENSOR_COUNT = 8'h04;
	localparam logic [7:0] ARC_FAST_COUNT   = 8'h02;
	localparam logic [7:0] ARC_BI_COUNT     = 8'h01;
	localparam logic [7:0] COMM_CARD_COUNT  = 8'h01;
	localparam logic [7:0] ZERO8            = 8'h00;

	// ------------------------------------------------------------------------
	// scan sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_RESET = 3'b000,
		ST_CPU   = 3'b001,
		ST_SEL   = 3'b010,
		ST_CHK   = 3'b011,
		ST_DONE  = 3'b100
	} ssn_state_t;

	// ------------------------------------------------------------------------
	// designations reserved for one slot; base_a is first input, output,
	// light sensor or port number, base_b first fast output, base_c arc input
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic      valid;
		ssn_type_t kind;
		logic [7:0] base_a;
		logic [7:0] count_a;
		logic [7:0] base_b;
		logic [7:0] base_c;
	} ssn_desig_t;

	localparam ssn_desig_t DESIG_NONE = '0;

	// ------------------------------------------------------------------------
	// running totals of designations handed out
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] di_last;
		logic [7:0] do_last;
		logic [7:0] sensor_last;
		logic [7:0] fast_last;
		logic [7:0] arc_bi_last;
		logic [7:0] comm_last;
	} ssn_totals_t;

endpackage : ssn_pkg
